// [hdl/ivfl_pkg.sv]
package ivfl_pkg;

  // APB word offsets of the registers.
  localparam logic [7:0] IVFL_FLAG_OFS = 8'h00;
  localparam logic [7:0] IVFL_ENABLE_OFS = 8'h04;
  localparam logic [7:0] IVFL_INT_STAT_OFS = 8'h08;
  localparam logic [7:0] IVFL_INT_MASK_OFS = 8'h0C;
  localparam logic [7:0] IVFL_VEC_STAT_OFS = 8'h10;
  localparam logic [7:0] IVFL_TABLE_SEL_OFS = 8'h14;

  localparam logic [15:0] IVFL_FLAG_RST = 16'h0000;
  localparam logic [15:0] IVFL_FLAG_IMPL = 16'hDFFF;
  localparam logic [3:0] IVFL_ENABLE_IMPL = 4'hB;
  localparam logic [3:0] IVFL_ENABLE_RST = 4'h0;

  // Enable control bits.
  localparam int IVFL_EN_CHANGE = 3;
  localparam int IVFL_EN_I2C1_MASTER = 1;
  localparam int IVFL_EN_I2C1_SLAVE = 0;

  // Vector numbering and table layout.
  localparam logic [6:0] IVFL_IRQ_TO_VECTOR = 7'h08;
  localparam logic [23:0] IVFL_PRIMARY_BASE = 24'h000004;
  localparam logic [23:0] IVFL_ALTERNATE_BASE = 24'h000104;
  localparam int IVFL_NUM_SRC = 24;
  localparam int IVFL_NUM_TRAP = 8;

  // Source indices of the routed peripheral requests.
  typedef enum logic [4:0] {
    SRC_DMA4, SRC_TIMER6, SRC_TIMER7, SRC_I2C2_SLAVE, SRC_I2C2_MASTER,
    SRC_TIMER8, SRC_TIMER9, SRC_EXT3, SRC_EXT4, SRC_CAN2_RX, SRC_CAN2_EVENT,
    SRC_PWM_PERIOD, SRC_POS_COMPARE, SRC_DMA5, SRC_FAULT_A, SRC_FAULT_B,
    SRC_UART1_ERR, SRC_UART2_ERR, SRC_DMA6, SRC_DMA7, SRC_CAN1_TX, SRC_CAN2_TX,
    SRC_I2C1_MASTER, SRC_I2C1_SLAVE
  } ivfl_src_t;

  // Vector number per source; the two I2C1 enables gate low vectors.
  localparam logic [6:0] IVFL_VEC_NUM [IVFL_NUM_SRC] = '{
    7'h36, 7'h37, 7'h38,
    7'h39, 7'h3A,
    7'h3B, 7'h3C,
    7'h3D, 7'h3E,
    7'h3F, 7'h40,
    7'h41, 7'h42,
    7'h45,
    7'h47, 7'h48, 7'h49, 7'h4A,
    7'h4C, 7'h4D,
    7'h4E, 7'h4F,
    7'h19, 7'h18
  };

  localparam logic [6:0] IVFL_VEC_HIGHEST = 7'h4F;

  typedef struct packed {
    logic valid;
    logic [6:0] number;
    logic [23:0] primary_addr;
    logic [23:0] alternate_addr;
  } ivfl_vector_t;

  typedef struct packed {
    logic [15:0] flag;
    logic [3:0] enable;
  } ivfl_regs_t;

endpackage : ivfl_pkg

// [hdl/ivfl_vec_addr.sv]
module ivfl_vec_addr
  import ivfl_pkg::*;
(
  // Vector in
  input wire logic [6:0] vec_num_i,
  // Addresses out
  output logic [23:0] primary_o,
  output logic [23:0] alternate_o
);

  logic [23:0] word_ofs;

  // Each vector takes one program word, two address units apart.
  assign word_ofs = {16'h0000, vec_num_i, 1'b0};
  assign primary_o = IVFL_PRIMARY_BASE + word_ofs;
  assign alternate_o = IVFL_ALTERNATE_BASE + word_ofs;

endmodule // ivfl_vec_addr

// [hdl/ivfl_pick.sv]
module ivfl_pick
  import ivfl_pkg::*;
#(
  parameter int N = IVFL_NUM_SRC
)
(
  // Requests
  input wire logic [N-1:0] req_i,
  // Selection
  output logic any_o,
  output logic [6:0] vec_o
);

  // Lowest vector number wins; ties cannot happen as numbers are unique.
  always_comb
  begin
    any_o = 1'b0;
    vec_o = 7'h00;
    for (int i = 0; i < N; i++)
    begin
      if (req_i[i] && (!any_o || IVFL_VEC_NUM[i] < vec_o))
      begin
        any_o = 1'b1;
        vec_o = IVFL_VEC_NUM[i];
      end
    end
  end

endmodule // ivfl_pick

// [hdl/ivfl_top.sv]
module ivfl_top
  import ivfl_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Peripheral request pulses
  input wire logic [IVFL_NUM_SRC-1:0] src_req_i,
  input wire logic [15:0] flag_event_i,
  input wire logic change_notify_req_i,
  input wire logic [IVFL_NUM_TRAP-1:0] trap_i,
  // Core side
  input wire logic vec_ack_i,
  output ivfl_vector_t vector_o,
  output logic change_notify_irq_o,
  output logic irq_o
);

  ivfl_regs_t regs;
  logic [IVFL_NUM_SRC-1:0] pending;
  logic [IVFL_NUM_SRC-1:0] gated;
  logic [IVFL_NUM_TRAP-1:0] trap_pend;
  logic [3:0] int_stat;
  logic [3:0] int_mask;
  logic table_alt;
  logic wr_en;
  logic rd_en;
  logic [15:0] flag_set;
  logic pick_any;
  logic [6:0] pick_vec;
  logic [6:0] next_vec;
  logic next_valid;
  logic [23:0] prim_addr;
  logic [23:0] alt_addr;
  logic [3:0] ev;
  logic [31:0] next_rdata;

  assign wr_en = psel_i && penable_i && pwrite_i;
  assign rd_en = psel_i && !penable_i && !pwrite_i;

  // Flag register: hardware set wins over a software write of zero.
  assign flag_set = flag_event_i & IVFL_FLAG_IMPL;
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      regs.flag <= IVFL_FLAG_RST;
    else if (wr_en && paddr_i == IVFL_FLAG_OFS)
      regs.flag <= (pwdata_i[15:0] & IVFL_FLAG_IMPL) | flag_set;
    else
      regs.flag <= regs.flag | flag_set;
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      regs.enable <= IVFL_ENABLE_RST;
    else if (wr_en && paddr_i == IVFL_ENABLE_OFS)
      regs.enable <= pwdata_i[3:0] & IVFL_ENABLE_IMPL;
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      int_mask <= 4'h0;
      table_alt <= 1'b0;
    end
    else if (wr_en && paddr_i == IVFL_INT_MASK_OFS)
      int_mask <= pwdata_i[3:0];
    else if (wr_en && paddr_i == IVFL_TABLE_SEL_OFS)
      table_alt <= pwdata_i[0];
  end

  // Pending source requests latch until the core acknowledges the vector.
  genvar g;
  generate
    for (g = 0; g < IVFL_NUM_SRC; g++)
    begin : g_pend
      always_ff @(posedge sys_clk_i or negedge arst_n_i)
      begin
        if (!arst_n_i)
          pending[g] <= 1'b0;
        else if (src_req_i[g])
          pending[g] <= 1'b1;
        else if (vec_ack_i && vector_o.valid && vector_o.number == IVFL_VEC_NUM[g])
          pending[g] <= 1'b0;
      end
    end
  endgenerate

  // Only the I2C1 pair has its enables here; other enables live elsewhere.
  always_comb
  begin
    gated = pending;
    gated[SRC_I2C1_MASTER] = pending[SRC_I2C1_MASTER] && regs.enable[IVFL_EN_I2C1_MASTER];
    gated[SRC_I2C1_SLAVE] = pending[SRC_I2C1_SLAVE] && regs.enable[IVFL_EN_I2C1_SLAVE];
  end

  ivfl_pick #(.N(IVFL_NUM_SRC)) u_pick (
    .req_i(gated),
    .any_o(pick_any),
    .vec_o(pick_vec)
  );

  // Traps outrank every peripheral; vectors 0, 6 and 7 are reserved.
  // A trap raised in the cycle its vector is taken stays pending, so none is lost.
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      trap_pend <= '0;
    else
      trap_pend <= ((trap_pend &
                     ~((vec_ack_i && vector_o.valid && vector_o.number < 7'h08) ?
                       (8'h01 << vector_o.number[2:0]) : 8'h00)) | trap_i) & 8'h3E;
  end

  always_comb
  begin
    next_valid = pick_any;
    next_vec = pick_vec;
    for (int t = IVFL_NUM_TRAP - 1; t >= 0; t--)
    begin
      if (trap_pend[t])
      begin
        next_valid = 1'b1;
        next_vec = 7'(t);
      end
    end
  end

  ivfl_vec_addr u_addr (
    .vec_num_i(next_vec),
    .primary_o(prim_addr),
    .alternate_o(alt_addr)
  );

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      vector_o <= '0;
    else if (vec_ack_i && vector_o.valid)
      vector_o <= '0;
    else
    begin
      vector_o.valid <= next_valid;
      vector_o.number <= next_vec;
      vector_o.primary_addr <= prim_addr;
      vector_o.alternate_addr <= alt_addr;
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      change_notify_irq_o <= 1'b0;
    else
      change_notify_irq_o <= change_notify_req_i && regs.enable[IVFL_EN_CHANGE];
  end

  // Sticky events: flag set, trap seen, vector issued, vector acknowledged.
  assign ev = {vec_ack_i && vector_o.valid, next_valid && !vector_o.valid,
               |trap_i, |flag_set};
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      int_stat <= 4'h0;
    else if (wr_en && paddr_i == IVFL_INT_STAT_OFS)
      int_stat <= (int_stat & ~pwdata_i[3:0]) | ev;
    else
      int_stat <= int_stat | ev;
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      irq_o <= 1'b0;
    else
      irq_o <= |(int_stat & int_mask);
  end

  always_comb
  begin
    unique case (paddr_i)
      IVFL_FLAG_OFS: next_rdata = {16'h0000, regs.flag};
      IVFL_ENABLE_OFS: next_rdata = {28'h0000000, regs.enable};
      IVFL_INT_STAT_OFS: next_rdata = {28'h0000000, int_stat};
      IVFL_INT_MASK_OFS: next_rdata = {28'h0000000, int_mask};
      IVFL_VEC_STAT_OFS: next_rdata = {24'h000000, vector_o.valid, vector_o.number};
      IVFL_TABLE_SEL_OFS: next_rdata = {31'h00000000, table_alt};
      default: next_rdata = 32'h00000000;
    endcase
  end

  // No wait state: read data is captured in setup, answered in access.
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      prdata_o <= 32'h00000000;
      pslverr_o <= 1'b0;
      pready_o <= 1'b0;
    end
    else
    begin
      pready_o <= psel_i && !penable_i;
      if (rd_en)
        prdata_o <= next_rdata;
      pslverr_o <= psel_i && !penable_i && paddr_i > IVFL_TABLE_SEL_OFS;
    end
  end

  flag_sets_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    flag_event_i[15] |=> regs.flag[15]) else $error("flag not set");
  flag_bit13_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    !regs.flag[13]) else $error("unused flag set");
  en_bit2_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    !regs.enable[2]) else $error("enable bit 2 set");
  cn_gate_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    change_notify_irq_o |-> $past(regs.enable[IVFL_EN_CHANGE])) else $error("cn ungated");
  i2c1_gate_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    vector_o.valid && vector_o.number == 7'h19 |-> $past(regs.enable[1]))
    else $error("i2c1 ungated");
  no_reserved_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    vector_o.valid |-> !(vector_o.number inside {7'h00, 7'h06, 7'h07, 7'h43, 7'h44, 7'h46,
    7'h4B} || vector_o.number > IVFL_VEC_HIGHEST)) else $error("reserved vector");
  alt_addr_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    vector_o.valid |-> vector_o.alternate_addr == vector_o.primary_addr + 24'h000100)
    else $error("alt address");
  dma4_vec_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    src_req_i == 24'h000001 && trap_i == 8'h00 && trap_pend == 8'h00 && pending == 24'h0 &&
    !vector_o.valid
    |=> ##1 vector_o.valid && vector_o.number == 7'h36 && vector_o.primary_addr == 24'h000070)
    else $error("dma4 vector");
  ext3_addr_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    vector_o.valid && vector_o.number == 7'h3D |-> vector_o.primary_addr == 24'h00007E)
    else $error("ext3 address");
  pready_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    psel_i && !penable_i |=> pready_o) else $error("no ready");

  // Priority, gating and register behaviour.
  trap_first_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    trap_pend != 8'h00 && !(vec_ack_i && vector_o.valid) |=>
    vector_o.valid && vector_o.number < 7'h08) else $error("trap not first");
  trap_keep_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    trap_i[2] |=> trap_pend[2]) else $error("trap lost");
  i2c1_slave_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    vector_o.valid && vector_o.number == 7'h18 |-> $past(regs.enable[0]))
    else $error("i2c1 slave ungated");
  flag_clear_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    wr_en && paddr_i == IVFL_FLAG_OFS && !pwdata_i[0] && !flag_event_i[0] |=> !regs.flag[0])
    else $error("flag not cleared");
  cn_follow_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    change_notify_req_i && regs.enable[IVFL_EN_CHANGE] |=> change_notify_irq_o)
    else $error("cn lost");
  en_read_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    pready_o && !pwrite_i && paddr_i == IVFL_ENABLE_OFS |-> !prdata_o[2])
    else $error("enable bit 2 read");
  ack_clear_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    vec_ack_i && vector_o.valid |=> !vector_o.valid) else $error("vector kept");
  err_addr_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    psel_i && !penable_i && paddr_i > IVFL_TABLE_SEL_OFS |=> pslverr_o)
    else $error("no slave error");
  idle_ready_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    !psel_i |=> !pready_o) else $error("stray ready");

  // The interrupt line trails the status by one clock.
  irq_set_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    |(int_stat & int_mask) |=> irq_o) else $error("irq missing");
  irq_clr_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    !(|(int_stat & int_mask)) |=> !irq_o) else $error("irq stuck");

  trap_c: cover property (@(posedge sys_clk_i) vector_o.valid && vector_o.number < 7'h08);
  periph_c: cover property (@(posedge sys_clk_i) vector_o.valid && vector_o.number == 7'h4F);
  irq_c: cover property (@(posedge sys_clk_i) irq_o);
  i2c1_c: cover property (@(posedge sys_clk_i) vector_o.valid && vector_o.number == 7'h19);
  cn_c: cover property (@(posedge sys_clk_i) change_notify_irq_o);

endmodule // ivfl_top

// [bench/ivfl_core_model.sv]
module ivfl_core_model
  import ivfl_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  // Vector fetch
  input wire ivfl_vector_t vector_i,
  input wire logic [1:0] delay_i,
  output logic vec_ack_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] wait_cnt;
  // The core may stall before taking a vector, so slow fetches are exercised too.
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      wait_cnt <= 2'h0;
      vec_ack_o <= 1'b0;
    end
    else
    begin
      vec_ack_o <= vector_i.valid && !vec_ack_o && wait_cnt == delay_i;
      wait_cnt <= (vector_i.valid && !vec_ack_o && wait_cnt != delay_i) ? wait_cnt + 2'h1 : 2'h0;
    end
  end
endmodule // ivfl_core_model

// [bench/tb.sv]
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fails++; \
  $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import ivfl_pkg::*;
  logic sys_clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic change_notify_req_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0;
  logic [IVFL_NUM_SRC-1:0] src_req_i = '0;
  logic [15:0] flag_event_i = 16'h0000;
  logic [IVFL_NUM_TRAP-1:0] trap_i = '0;
  logic [1:0] delay = 2'h0;
  logic [31:0] prdata_o;
  logic [31:0] rd;
  logic pready_o, pslverr_o, vec_ack_i, change_notify_irq_o, irq_o, err;
  ivfl_vector_t vector_o;
  int fails = 0;
  int compares = 0;
  // Expected vector per source index, in the order of the source enumeration.
  localparam logic [6:0] VEC_EXP [IVFL_NUM_SRC] = '{
    7'h36, 7'h37, 7'h38, 7'h39, 7'h3A, 7'h3B, 7'h3C, 7'h3D, 7'h3E, 7'h3F, 7'h40, 7'h41,
    7'h42, 7'h45, 7'h47, 7'h48, 7'h49, 7'h4A, 7'h4C, 7'h4D, 7'h4E, 7'h4F, 7'h19, 7'h18};

  ivfl_top dut_u (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .src_req_i(src_req_i),
    .flag_event_i(flag_event_i), .change_notify_req_i(change_notify_req_i), .trap_i(trap_i),
    .vec_ack_i(vec_ack_i), .vector_o(vector_o), .change_notify_irq_o(change_notify_irq_o),
    .irq_o(irq_o));
  ivfl_core_model core_u (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .vector_i(vector_o),
    .delay_i(delay), .vec_ack_o(vec_ack_i));

  always #10 sys_clk_i = ~sys_clk_i;

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge sys_clk_i);
    penable_i <= 1'b1;
    do @(posedge sys_clk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task automatic pulse(input logic [23:0] s, input logic [7:0] t, input logic [15:0] f);
    @(posedge sys_clk_i);
    src_req_i <= s;
    trap_i <= t;
    flag_event_i <= f;
    @(posedge sys_clk_i);
    src_req_i <= '0;
    trap_i <= '0;
    flag_event_i <= 16'h0000;
  endtask

  // Waits for the presented vector, checks it, then lets the core take it.
  task automatic wait_vec(input logic [6:0] num);
    int n = 0;
    while (vector_o.valid !== 1'b1 && n < 20)
    begin
      @(posedge sys_clk_i);
      n++;
    end
    `CHK(vector_o.valid, 1'b1)
    `CHK(vector_o.number, num)
    `CHK(vector_o.primary_addr, 24'h000004 + {num, 1'b0})
    `CHK(vector_o.alternate_addr, 24'h000104 + {num, 1'b0})
    while (vector_o.valid === 1'b1 && n < 40)
    begin
      @(posedge sys_clk_i);
      n++;
    end
  endtask

  task print_verdict;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    #(20 * 5000);
    fails++;
    print_verdict;
  end

  initial
  begin
    repeat (10) @(posedge sys_clk_i);
    arst_n_i <= 1'b1;
    apb(1'b0, IVFL_FLAG_OFS, 32'h0);
    `CHK(rd, 32'h0)
    apb(1'b0, IVFL_ENABLE_OFS, 32'h0);
    `CHK(rd, 32'h0)
    apb(1'b1, IVFL_ENABLE_OFS, 32'hF);
    apb(1'b0, IVFL_ENABLE_OFS, 32'h0);
    `CHK(rd, 32'hB)
    for (int i = 0; i < IVFL_NUM_SRC; i++)
    begin
      delay <= i[1:0];
      pulse(24'h1 << i, 8'h00, 16'h0000);
      wait_vec(VEC_EXP[i]);
    end
    for (int t = 1; t < 6; t++)
    begin
      pulse(24'h0, 8'h1 << t, 16'h0000);
      wait_vec(t[6:0]);
    end
    pulse(24'h1, 8'h04, 16'h0000);
    wait_vec(7'h02);
    wait_vec(7'h36);
    pulse(24'h0, 8'h00, 16'hFFFF);
    apb(1'b0, IVFL_FLAG_OFS, 32'h0);
    `CHK(rd, 32'hDFFF)
    apb(1'b1, IVFL_FLAG_OFS, 32'h0);
    apb(1'b0, IVFL_FLAG_OFS, 32'h0);
    `CHK(rd, 32'h0)
    change_notify_req_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    `CHK(change_notify_irq_o, 1'b1)
    apb(1'b1, IVFL_ENABLE_OFS, 32'h3);
    repeat (2) @(posedge sys_clk_i);
    `CHK(change_notify_irq_o, 1'b0)
    apb(1'b1, IVFL_INT_STAT_OFS, 32'hF);
    apb(1'b1, IVFL_INT_MASK_OFS, 32'h1);
    `CHK(irq_o, 1'b0)
    pulse(24'h0, 8'h00, 16'h0001);
    repeat (3) @(posedge sys_clk_i);
    `CHK(irq_o, 1'b1)
    apb(1'b1, IVFL_INT_MASK_OFS, 32'h0);
    repeat (2) @(posedge sys_clk_i);
    `CHK(irq_o, 1'b0)
    apb(1'b1, IVFL_FLAG_OFS, 32'h0);
    apb(1'b1, IVFL_INT_STAT_OFS, 32'hF);
    apb(1'b1, IVFL_INT_MASK_OFS, 32'h1);
    repeat (2) @(posedge sys_clk_i);
    `CHK(irq_o, 1'b0)
    apb(1'b0, 8'h18, 32'h0);
    `CHK(err, 1'b1)
    `CHK(rd, 32'h0)
    apb(1'b1, IVFL_ENABLE_OFS, 32'h0);
    pulse(24'h400000, 8'h00, 16'h0000);
    repeat (8) @(posedge sys_clk_i);
    `CHK(vector_o.valid, 1'b0)
    pulse(24'h0, 8'hC1, 16'h0000);
    repeat (4) @(posedge sys_clk_i);
    `CHK(vector_o.valid, 1'b0)
    apb(1'b1, IVFL_TABLE_SEL_OFS, 32'h1);
    apb(1'b0, IVFL_TABLE_SEL_OFS, 32'h0);
    `CHK(rd, 32'h1)
    pulse(24'h0, 8'h00, 16'h8000);
    apb(1'b0, IVFL_FLAG_OFS, 32'h0);
    `CHK(rd, 32'h8000)
    // Reset in mid-run must drop the stored flag, the select bit and the gated request.
    arst_n_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    `CHK(vector_o.valid, 1'b0)
    arst_n_i <= 1'b1;
    apb(1'b0, IVFL_FLAG_OFS, 32'h0);
    `CHK(rd, 32'h0)
    apb(1'b0, IVFL_TABLE_SEL_OFS, 32'h0);
    `CHK(rd, 32'h0)
    print_verdict;
  end
endmodule // tb
